//--- rtl/hpm_consts.svh
// Constants for the host port mailbox and boot register block.
`ifndef HPM_CONSTS_SVH
`define HPM_CONSTS_SVH
// Behaviour
// - CPU interrupt stays raised while inbound request bit 0 is set.
// - Inbound source code bits 7:1 are read/write by both, no effect.
// - Outbound source code bits 7:1 are read/write by both, no effect.
// - Host interrupt pin stays asserted while outbound request bit is set.
// - Reserved upper bits read zero; writers write zeros.
// - Address bits 9:2 hold next word address; bits 1:0 read zero.
// - In consecutive mode the address steps by four after each access.
// - Only host with select pin low writes address; CPU only reads it.
// - Data word holds RAM write data and receives RAM read data.
// - Data word doubles as a mailbox; CPU reads and writes it.
// - Boot control is read-only to the CPU; host alone changes it.
// - Boot control bits 7:1 take the guard pattern, read back zero.
// - Exclusive bit set stalls CPU RAM access until it clears.
// - Normal boot: exclusive bit starts at zero.
// - Host-port boot: exclusive bit starts at one until host clears it.
// - Exclusive control applies to the bank assigned to the CPU.
// - Direction bit zero increments, one decrements, only in consecutive.
// - Read command fetches the RAM word at the address into data.

// Index select codes seen by the host and CPU register offsets.
`define HPM_IDX_INBOUND   6'h00
`define HPM_IDX_OUTBOUND  6'h01
`define HPM_IDX_ADDRESS   6'h02
`define HPM_IDX_DATA      6'h03
`define HPM_IDX_BOOT      6'h04
// Field positions and reset values.
`define HPM_REQ_BIT       0
`define HPM_CODE_MSB      7
`define HPM_CODE_LSB      1
`define HPM_ADDR_MSB      9
`define HPM_ADDR_LSB      2
`define HPM_GUARD         8'ha5
`define HPM_ADDR_STEP     8'h01
`define HPM_DATA_RESET    32'h0000_0000
`define HPM_BYTE_RESET    8'h00
// Cycles after reset release before the boot strap is taken.
`define HPM_STRAP_WAIT    2'h3
`endif

//--- rtl/hpm_pkg.sv
// Types for the host port mailbox and boot register block.
package hpm_pkg;
  // One decoded register access from either side.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  sel;
    logic [31:0] data;
  } hpm_access_t;

  // Shared-RAM transfer sequencer states.
  typedef enum logic [1:0] {
    HPM_IDLE,
    HPM_READ,
    HPM_WRITE
  } hpm_ram_state_t;
endpackage

//--- rtl/hpm_regs.sv
// Host port interrupt, address, data and boot/exclusive registers.
`timescale 1ns/10ps
`include "hpm_consts.svh"
module hpm_regs (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Host parallel pins, asynchronous to i_ref_clk.
  input  wire logic        i_host_cs_n,
  input  wire logic        i_register_select_pin,
  input  wire logic        i_host_wr_n,
  input  wire logic        i_host_rd_n,
  input  wire logic [31:0] i_host_data,
  output logic      [31:0] o_host_data,
  output logic             o_host_data_oe,
  output logic             o_host_interrupt_pin_n,
  input  wire logic        i_host_boot_strap,
  // On-chip CPU register port.
  input  wire logic        i_cpu_wr,
  input  wire logic        i_cpu_rd,
  input  wire logic [5:0]  i_cpu_sel,
  input  wire logic [31:0] i_cpu_wdata,
  output logic      [31:0] o_cpu_rdata,
  output logic             o_cpu_port_interrupt,
  // CPU shared-RAM access gate for the CPU's bank.
  input  wire logic        i_cpu_ram_req,
  output logic             o_cpu_ram_go,
  output logic             o_cpu_ram_stall,
  // Transfer control from the mode control logic.
  input  wire logic        i_consec_mode,
  input  wire logic        i_step_direction_bit,
  input  wire logic        i_ram_read_cmd,
  input  wire logic        i_ram_write_cmd,
  // Shared-RAM port for host-side transfers.
  output logic             o_ram_req,
  output logic             o_ram_we,
  output logic      [9:0]  o_ram_addr,
  output logic      [31:0] o_ram_wdata,
  input  wire logic [31:0] i_ram_rdata,
  input  wire logic        i_ram_ack,
  output logic             o_exclusive_access_bit
);

  // True when a write access hits the given register select code.
  function automatic logic hits(input hpm_pkg::hpm_access_t a,
                                input logic [5:0] code);
    hits = a.wr && (a.sel == code);
  endfunction

  // --------------------------------------------------------------
  // Host pin synchronisers
  // --------------------------------------------------------------
  logic [3:0]  pins_s1_q;
  logic [3:0]  pins_s2_q;
  logic [31:0] data_s1_q;
  logic [31:0] data_s2_q;
  logic        wr_s3_q;
  logic        strap_s1_q;
  logic        strap_s2_q;

  // Two stages on every pin; the third write flop only feeds the edge.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pins_s1_q  <= 4'hf;
      pins_s2_q  <= 4'hf;
      data_s1_q  <= `HPM_DATA_RESET;
      data_s2_q  <= `HPM_DATA_RESET;
      wr_s3_q    <= 1'b0;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      pins_s1_q  <= {i_host_cs_n, i_register_select_pin,
                     i_host_wr_n, i_host_rd_n};
      pins_s2_q  <= pins_s1_q;
      data_s1_q  <= i_host_data;
      data_s2_q  <= data_s1_q;
      wr_s3_q    <= ~pins_s2_q[3] & ~pins_s2_q[1];
      strap_s1_q <= i_host_boot_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  // --------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------
  logic [5:0]          register_index_q;
  hpm_pkg::hpm_access_t host_acc;
  hpm_pkg::hpm_access_t cpu_acc;
  wire                 host_sel  = ~pins_s2_q[3];
  wire                 host_wr_l = host_sel & ~pins_s2_q[1];
  wire                 host_wr_p = host_wr_l & ~wr_s3_q;
  wire                 host_rs   = pins_s2_q[2];
  wire                 host_rd_l = host_sel & ~pins_s2_q[0];

  // Select pin high writes the index; low reaches the indexed register.
  assign host_acc.wr   = host_wr_p & ~host_rs;
  assign host_acc.rd   = host_rd_l & ~host_rs;
  assign host_acc.sel  = register_index_q;
  assign host_acc.data = data_s2_q;
  assign cpu_acc.wr    = i_cpu_wr;
  assign cpu_acc.rd    = i_cpu_rd;
  assign cpu_acc.sel   = i_cpu_sel;
  assign cpu_acc.data  = i_cpu_wdata;

  wire h_in   = hits(host_acc, `HPM_IDX_INBOUND);
  wire h_out  = hits(host_acc, `HPM_IDX_OUTBOUND);
  wire h_addr = hits(host_acc, `HPM_IDX_ADDRESS);
  wire h_data = hits(host_acc, `HPM_IDX_DATA);
  wire h_boot = hits(host_acc, `HPM_IDX_BOOT);
  wire c_in   = hits(cpu_acc, `HPM_IDX_INBOUND);
  wire c_out  = hits(cpu_acc, `HPM_IDX_OUTBOUND);
  wire c_data = hits(cpu_acc, `HPM_IDX_DATA);

  // Index register, written while the select pin is high.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      register_index_q <= 6'h00;
    end else if (host_wr_p && host_rs) begin
      register_index_q <= data_s2_q[5:0];
    end
  end

  // --------------------------------------------------------------
  // Interrupt registers
  // --------------------------------------------------------------
  logic [7:0] inbound_interrupt_control_q;
  logic [7:0] outbound_interrupt_control_q;
  logic [7:0] inbound_d;
  logic [7:0] outbound_d;

  // Both sides write the code and request; the host wins a tie.
  assign inbound_d  = h_in  ? host_acc.data[7:0] :
                      c_in  ? cpu_acc.data[7:0]  :
                      inbound_interrupt_control_q;
  assign outbound_d = h_out ? host_acc.data[7:0] :
                      c_out ? cpu_acc.data[7:0]  :
                      outbound_interrupt_control_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      inbound_interrupt_control_q  <= `HPM_BYTE_RESET;
      outbound_interrupt_control_q <= `HPM_BYTE_RESET;
    end else begin
      inbound_interrupt_control_q  <= inbound_d;
      outbound_interrupt_control_q <= outbound_d;
    end
  end

  // Request bits drive the interrupt lines as levels, not pulses.
  assign o_cpu_port_interrupt =
    inbound_interrupt_control_q[`HPM_REQ_BIT];
  assign o_host_interrupt_pin_n =
    ~outbound_interrupt_control_q[`HPM_REQ_BIT];

  // --------------------------------------------------------------
  // Shared-RAM transfer sequencer
  // --------------------------------------------------------------
  hpm_pkg::hpm_ram_state_t ram_state_q;
  hpm_pkg::hpm_ram_state_t ram_state_d;
  logic [7:0]  word_address_field_q;
  logic [7:0]  step_addr;
  logic [31:0] shared_data_window_q;
  wire         ram_done = (ram_state_q != hpm_pkg::HPM_IDLE) & i_ram_ack;
  wire         do_step  = ram_done & i_consec_mode;

  // Direction only matters in consecutive mode; one word is four bytes.
  assign step_addr = i_step_direction_bit ?
    word_address_field_q - `HPM_ADDR_STEP :
    word_address_field_q + `HPM_ADDR_STEP;

  always_comb begin
    ram_state_d = ram_state_q;
    unique case (ram_state_q)
      hpm_pkg::HPM_IDLE: begin
        if (i_ram_read_cmd) begin
          ram_state_d = hpm_pkg::HPM_READ;
        end else if (i_ram_write_cmd) begin
          ram_state_d = hpm_pkg::HPM_WRITE;
        end
      end
      hpm_pkg::HPM_READ,
      hpm_pkg::HPM_WRITE: begin
        if (i_ram_ack) begin
          ram_state_d = hpm_pkg::HPM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ram_state_q <= hpm_pkg::HPM_IDLE;
    end else begin
      ram_state_q <= ram_state_d;
    end
  end

  assign o_ram_req   = ram_state_q != hpm_pkg::HPM_IDLE;
  assign o_ram_we    = ram_state_q == hpm_pkg::HPM_WRITE;
  assign o_ram_addr  = {word_address_field_q, 2'b00};
  assign o_ram_wdata = shared_data_window_q;

  // Only the host may load the address; a host write beats the step.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      word_address_field_q <= `HPM_BYTE_RESET;
    end else if (h_addr) begin
      word_address_field_q <=
        host_acc.data[`HPM_ADDR_MSB:`HPM_ADDR_LSB];
    end else if (do_step) begin
      word_address_field_q <= step_addr;
    end
  end

  // RAM read data lands first; otherwise the word is a mailbox.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shared_data_window_q <= `HPM_DATA_RESET;
    end else if (ram_done && !o_ram_we) begin
      shared_data_window_q <= i_ram_rdata;
    end else if (h_data) begin
      shared_data_window_q <= host_acc.data;
    end else if (c_data) begin
      shared_data_window_q <= cpu_acc.data;
    end
  end

  // --------------------------------------------------------------
  // Boot and exclusive access control
  // --------------------------------------------------------------
  logic       exclusive_access_bit_q;
  logic [1:0] strap_wait_q;
  wire        strap_take = strap_wait_q == (`HPM_STRAP_WAIT - 2'h1);
  wire        guard_ok   = host_acc.data[7:0] == `HPM_GUARD;

  // The strap is taken once the synchroniser has settled after reset,
  // so the boot mode never depends on the reset edge itself.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_wait_q <= 2'h0;
    end else if (strap_wait_q != `HPM_STRAP_WAIT) begin
      strap_wait_q <= strap_wait_q + 2'h1;
    end
  end

  // Only the host writes; a set needs the full guard byte.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      exclusive_access_bit_q <= 1'b0;
    end else if (strap_take) begin
      exclusive_access_bit_q <= strap_s2_q;
    end else if (h_boot && guard_ok) begin
      exclusive_access_bit_q <= 1'b1;
    end else if (h_boot && !host_acc.data[0]) begin
      exclusive_access_bit_q <= 1'b0;
    end
    // A set without the guard byte falls through unchanged.
  end

  assign o_exclusive_access_bit = exclusive_access_bit_q;
  // The gate covers whichever bank is currently the CPU's.
  assign o_cpu_ram_stall = i_cpu_ram_req & exclusive_access_bit_q;
  assign o_cpu_ram_go    = i_cpu_ram_req & ~exclusive_access_bit_q;

  // --------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------
  logic [31:0] host_view;
  logic [31:0] cpu_view;

  // Shared read mux; guard bits and reserved bits always read zero.
  function automatic logic [31:0] view(input logic [5:0] sel);
    view = 32'h0000_0000;
    if (sel == `HPM_IDX_INBOUND) begin
      view = {24'h00_0000, inbound_interrupt_control_q};
    end else if (sel == `HPM_IDX_OUTBOUND) begin
      view = {24'h00_0000, outbound_interrupt_control_q};
    end else if (sel == `HPM_IDX_ADDRESS) begin
      view = {22'h00_0000, word_address_field_q, 2'b00};
    end else if (sel == `HPM_IDX_DATA) begin
      view = shared_data_window_q;
    end else if (sel == `HPM_IDX_BOOT) begin
      view = {31'h0000_0000, exclusive_access_bit_q};
    end
  endfunction

  assign host_view = host_rs ? {26'h000_0000, register_index_q}
                             : view(host_acc.sel);
  assign cpu_view  = view(cpu_acc.sel);

  // Read data comes from flops; the pin drives only during a read.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_data    <= `HPM_DATA_RESET;
      o_host_data_oe <= 1'b0;
      o_cpu_rdata    <= `HPM_DATA_RESET;
    end else begin
      o_host_data    <= host_view;
      o_host_data_oe <= host_rd_l;
      o_cpu_rdata    <= cpu_acc.rd ? cpu_view : `HPM_DATA_RESET;
    end
  end

endmodule // hpm_regs

//--- verification/hpm_ram_model.sv
// Shared-RAM responder on the far side of the transfer port.
`timescale 1ns/10ps
module hpm_ram_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_slow,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [9:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  output logic      [31:0] o_rdata,
  output logic             o_ack
);
  logic [31:0] mem [256];
  logic [1:0]  wait_q;
  // Each word starts as its index copied into every byte.
  initial for (int i = 0; i < 256; i++) mem[i] = {4{i[7:0]}};
  // Outside an ack the bus shows the inverse, so stale data never matches.
  assign o_rdata = o_ack ? mem[i_addr[9:2]] : ~mem[i_addr[9:2]];
  // Answers after zero or three wait cycles; ack stands one cycle.
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack  <= 1'b0;
      wait_q <= 2'h0;
    end else if (i_req && !o_ack && wait_q == 2'h0) begin
      o_ack <= 1'b1;
      if (i_we) mem[i_addr[9:2]] <= i_wdata;
    end else begin
      o_ack <= 1'b0;
      if (!i_req) wait_q <= i_slow ? 2'h3 : 2'h0;
      else if (!o_ack) wait_q <= wait_q - 2'h1;
    end
  end
endmodule // hpm_ram_model

//--- verification/hpm_regs_props.sv
// Concurrent checks on the host port register block.
`timescale 1ns/10ps
module hpm_regs_props (
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_cpu_ram_req,
  input wire logic       o_cpu_ram_go,
  input wire logic       o_cpu_ram_stall,
  input wire logic       o_exclusive_access_bit,
  input wire logic       i_consec_mode,
  input wire logic       i_step_direction_bit,
  input wire logic       i_ram_read_cmd,
  input wire logic       i_ram_ack,
  input wire logic       o_ram_req,
  input wire logic       o_ram_we,
  input wire logic [9:0] o_ram_addr
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  sequence s_done;
    o_ram_req && i_ram_ack;
  endsequence
  sequence s_freed;
    o_cpu_ram_stall ##1 (i_cpu_ram_req && !o_exclusive_access_bit);
  endsequence
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_go;
    i_cpu_ram_req && !o_exclusive_access_bit |-> o_cpu_ram_go;
  endproperty
  a_go: assert property (p_go) else $error("CPU access held");
  property p_stall;
    i_cpu_ram_req && o_exclusive_access_bit
      |-> o_cpu_ram_stall && !o_cpu_ram_go;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");
  property p_rel;
    s_freed |-> o_cpu_ram_go;
  endproperty
  a_rel: assert property (p_rel) else $error("stall kept");
  property p_inc;
    s_done ##0 (i_consec_mode && !i_step_direction_bit)
      |=> o_ram_addr == $past(o_ram_addr) + 10'h004;
  endproperty
  a_inc: assert property (p_inc) else $error("no increment");
  property p_dec;
    s_done ##0 (i_consec_mode && i_step_direction_bit)
      |=> o_ram_addr == $past(o_ram_addr) - 10'h004;
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement");
  property p_keep;
    s_done ##0 !i_consec_mode |=> $stable(o_ram_addr);
  endproperty
  a_keep: assert property (p_keep) else $error("address moved");
  property p_hold;
    o_ram_req && !i_ram_ack |=> o_ram_req && $stable(o_ram_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("req dropped");
  property p_cmd;
    i_ram_read_cmd && !o_ram_req |=> o_ram_req && !o_ram_we;
  endproperty
  a_cmd: assert property (p_cmd) else $error("read not started");
  property p_align;
    o_ram_addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("unaligned");
endmodule // hpm_regs_props
bind hpm_regs hpm_regs_props u_props (.*);

//--- verification/tb_top.sv
// Self-checking bench for the host port mailbox and boot registers.
`timescale 1ns/10ps
`include "hpm_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clk = 0, rst = 1, cs_n = 1, rs = 1, wr_n = 1, rd_n = 1, strap = 0;
  logic cwr = 0, crd = 0, creq = 0, consec = 0, dir = 0, rcmd = 0;
  logic wcmd = 0, slow = 0, hs = 0, rd_q = 0, hoe, int_n, cirq, go;
  logic stall, rreq, rwe, ack, excl;
  logic [5:0]  csel = 6'h00;
  logic [9:0]  raddr;
  logic [7:0]  w;
  logic [31:0] hd = 0, cwd = 0, hq, cpd, rwd, rrd, r, ex;
  logic [31:0] exp_q [$];
  int          err_count = 0;
  int          check_count = 0;
  hpm_regs DUT (
    .i_ref_clk(clk), .i_rst(rst), .i_host_cs_n(cs_n),
    .i_register_select_pin(rs), .i_host_wr_n(wr_n), .i_host_rd_n(rd_n),
    .i_host_data(hd), .o_host_data(hq), .o_host_data_oe(hoe),
    .o_host_interrupt_pin_n(int_n), .i_host_boot_strap(strap),
    .i_cpu_wr(cwr), .i_cpu_rd(crd), .i_cpu_sel(csel), .i_cpu_wdata(cwd),
    .o_cpu_rdata(cpd), .o_cpu_port_interrupt(cirq), .i_cpu_ram_req(creq),
    .o_cpu_ram_go(go), .o_cpu_ram_stall(stall), .i_consec_mode(consec),
    .i_step_direction_bit(dir), .i_ram_read_cmd(rcmd),
    .i_ram_write_cmd(wcmd), .o_ram_req(rreq), .o_ram_we(rwe),
    .o_ram_addr(raddr), .o_ram_wdata(rwd), .i_ram_rdata(rrd),
    .i_ram_ack(ack), .o_exclusive_access_bit(excl));
  hpm_ram_model u_ram (
    .i_ref_clk(clk), .i_rst(rst), .i_slow(slow), .i_req(rreq), .i_we(rwe),
    .i_addr(raddr), .i_wdata(rwd), .o_rdata(rrd), .o_ack(ack));
  // ---------------------------------------------------------------
  // Clock, monitor and bus tasks
  // ---------------------------------------------------------------
  always #2 clk = ~clk;
  // Compares each settled read result with the oldest noted value.
  always @(posedge clk) begin
    rd_q <= crd;
    if (rd_q || hs) begin
      ex = exp_q.pop_front();
      `CHK(rd_q ? cpd : hq, ex)
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // The strobe is held four cycles, past the pin synchroniser.
  task automatic hwr(input logic sel, input logic [31:0] d);
    rs <= sel;
    cs_n <= 1'b0;
    hd <= d;
    wr_n <= 1'b0;
    tick(4);
    wr_n <= 1'b1;
    cs_n <= 1'b1;
    tick(4);
  endtask
  task automatic hreg(input logic [5:0] idx, input logic [31:0] d);
    hwr(1'b1, {26'h0, idx});
    hwr(1'b0, d);
  endtask
  task automatic hrd(input logic [5:0] idx, input logic [31:0] e);
    hwr(1'b1, {26'h0, idx});
    rs <= 1'b0;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    tick(6);
    `CHK(hoe, 1'b1)
    exp_q.push_back(e);
    hs <= 1'b1;
    tick(1);
    hs <= 1'b0;
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    tick(2);
  endtask
  task automatic cpu_wr(input logic [5:0] s, input logic [31:0] d);
    csel <= s;
    cwd <= d;
    cwr <= 1'b1;
    tick(1);
    cwr <= 1'b0;
    tick(1);
  endtask
  task automatic cpu_rd(input logic [5:0] s, input logic [31:0] e);
    csel <= s;
    crd <= 1'b1;
    exp_q.push_back(e);
    tick(1);
    crd <= 1'b0;
    tick(2);
  endtask
  // Waits for the far side to end the transfer, within a bound.
  task automatic ram_op(input logic rd);
    int n;
    rcmd <= rd;
    wcmd <= !rd;
    tick(1);
    rcmd <= 1'b0;
    wcmd <= 1'b0;
    // Look at the request only once it has settled after the command edge.
    @(negedge clk);
    for (n = 0; n < 20 && rreq !== 1'b0; n++) @(negedge clk);
    if (n == 20) begin
      err_count++;
      $display("mismatch %0t shared-RAM transfer timed out", $time);
      conclude();
    end else begin
      tick(1);
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(56));
    tick(12);
    rst <= 1'b0;
    tick(4);
    `CHK(excl, 1'b0)
    cpu_rd(`HPM_IDX_DATA, `HPM_DATA_RESET);
    r = $urandom();
    hreg(`HPM_IDX_INBOUND, {24'h0, r[7:1], 1'b1});
    cpu_rd(`HPM_IDX_INBOUND, {24'h0, r[7:1], 1'b1});
    `CHK(cirq, 1'b1)
    cpu_wr(`HPM_IDX_INBOUND, 32'h0);
    `CHK(cirq, 1'b0)
    r = $urandom();
    cpu_wr(`HPM_IDX_OUTBOUND, {24'h0, r[7:1], 1'b1});
    `CHK(int_n, 1'b0)
    hrd(`HPM_IDX_OUTBOUND, {24'h0, r[7:1], 1'b1});
    hreg(`HPM_IDX_OUTBOUND, 32'h0);
    `CHK(int_n, 1'b1)
    r = $urandom();
    cpu_wr(`HPM_IDX_DATA, r);
    hrd(`HPM_IDX_DATA, r);
    hreg(`HPM_IDX_ADDRESS, 32'h0000_03fc);
    cpu_wr(`HPM_IDX_ADDRESS, 32'h0);
    cpu_rd(`HPM_IDX_ADDRESS, 32'h0000_03fc);
    // Step down, step up, then no step with consecutive mode off.
    w = 8'hff;
    for (int i = 0; i < 3; i++) begin
      consec <= (i < 2);
      dir <= (i == 0);
      slow <= i[0];
      ram_op(1'b1);
      cpu_rd(`HPM_IDX_DATA, {4{w}});
      w = (i == 0) ? 8'hfe : 8'hff;
      cpu_rd(`HPM_IDX_ADDRESS, {22'h0, w, 2'h0});
    end
    r = $urandom();
    hreg(`HPM_IDX_DATA, r);
    ram_op(1'b0);
    `CHK(u_ram.mem[8'hff], r)
    cpu_wr(`HPM_IDX_BOOT, 32'h0000_00a5);
    hreg(`HPM_IDX_BOOT, 32'h0000_0001);
    hrd(`HPM_IDX_BOOT, 32'h0);
    hreg(`HPM_IDX_BOOT, {24'h0, `HPM_GUARD});
    hrd(`HPM_IDX_BOOT, 32'h1);
    creq <= 1'b1;
    tick(1);
    `CHK(stall, 1'b1)
    hreg(`HPM_IDX_BOOT, 32'h0);
    `CHK(go, 1'b1)
    creq <= 1'b0;
    strap <= 1'b1;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(4);
    `CHK(excl, 1'b1)
    hreg(`HPM_IDX_BOOT, 32'h0);
    `CHK(excl, 1'b0)
    conclude();
  end
endmodule // tb_top
